// *** shared/cpd_pkg.sv ***
/*
 * Shared constants of the capacitive detect block: option field layout,
 * register offsets, reset values, bank masks and timing figures.
 * Assumes a 20 MHz system clock and 16-bit sample counts.
 */
package cpd_pkg;

  localparam int CNT_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Clock and time base
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;

  // Host control pulse window, strictly between the first two figures; external halt and recalibration delay
  localparam int PULSE_MIN_MS = 25;
  localparam int PULSE_MAX_MS = 35;
  localparam int EXT_HALT_MS = 40;
  localparam int RECAL_DELAY_MS = 500;

  // Filter halt times
  localparam int HALT_18_S = 18;
  localparam int HALT_60_S = 60;
  localparam int HALT_3_S = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_THRESHOLD_LOGIC = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_HALT_STREAM = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_TUNING_BASE = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STATE = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_INT_CLEAR = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_LTA_LO = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_LTA_HI = 4'h8;

  // Reset values
  localparam logic [7:0] RST_THRESHOLD_LOGIC = 8'h00;
  localparam logic [7:0] RST_HALT_STREAM = 8'h00;
  localparam logic [7:0] RST_TUNING_BASE = 8'h00;

  // Implemented bits of each option bank
  localparam logic [7:0] MASK_BANK0 = 8'hfb;
  localparam logic [7:0] MASK_BANK1 = 8'h99;
  localparam logic [7:0] MASK_BANK2 = 8'h06;

  // Field positions
  localparam int TOUCH_THRESHOLD_SEL_LSB = 5;
  localparam int PTHR_LSB = 3;
  localparam int POL_BIT = 1;
  localparam int EXTMODE_BIT = 0;
  localparam int STREAM_BIT = 7;
  localparam int HALT_LSB = 3;
  localparam int DIR_BIT = 0;
  localparam int BASE_LSB = 1;

  // Interrupt event bits
  localparam int EV_PROX = 0;
  localparam int EV_TOUCH = 1;
  localparam int EV_RECAL = 2;
  localparam int EV_RELEASE = 3;
  localparam int EV_RESEED = 4;
  localparam int EV_N = 5;

  typedef enum logic [1:0] {
    CPD_IDLE  = 2'b00,
    CPD_PROX  = 2'b01,
    CPD_TOUCH = 2'b11,
    CPD_TRACK = 2'b10
  } cpd_state_t;

endpackage

// *** hw/cpd_pin_sync.sv ***
/*
 * Three-stage synchroniser for a pin from outside the clock domain.
 * The output moves only when the second and third stages agree.
 */
`timescale 1ns/1ps
`default_nettype none

module cpd_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  // Pin and clean level
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else if (clk_en) begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level_o <= RST_VAL;
    end else if (clk_en && s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end

endmodule

`default_nettype wire

// *** hw/cpd_ctrl_timer.sv ***
/*
 * Measures how long the host holds the control input high, in ms ticks.
 * Gives a hold level past the external halt time and a one-cycle pulse
 * for a reseed pulse of valid length. Assumes a synchronised input.
 */
`timescale 1ns/1ps
`default_nettype none

module cpd_ctrl_timer #(
  parameter int HALT_MS = cpd_pkg::EXT_HALT_MS
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  // Inputs
  input  wire logic enable,
  input  wire logic ms_tick,
  input  wire logic ctrl_level,
  // Results
  output logic      hold_o,
  output logic      reseed_o,
  output logic      release_o
);
  import cpd_pkg::*;

  initial begin
    if (HALT_MS <= PULSE_MAX_MS || HALT_MS > 60000) begin
      $error("cpd_ctrl_timer: HALT_MS must exceed the pulse window");
    end
  end

  logic [15:0] ms_q;
  logic        prev_q;
  logic        fall;

  assign fall = prev_q && !ctrl_level;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ms_q <= 16'h0000;
      prev_q <= 1'b0;
    end else if (clk_en) begin
      prev_q <= ctrl_level && enable;
      if (!(ctrl_level && enable)) begin
        ms_q <= 16'h0000;
      end else if (ms_tick && ms_q != 16'hffff) begin
        ms_q <= ms_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_o <= 1'b0;
      reseed_o <= 1'b0;
      release_o <= 1'b0;
    end else if (clk_en) begin
      hold_o <= ctrl_level && enable && ms_q >= 16'(HALT_MS);
      // Strict window: counts 25 and 35 are both refused
      reseed_o <= fall && ms_q > 16'(PULSE_MIN_MS) && ms_q < 16'(PULSE_MAX_MS);
      release_o <= fall && ms_q >= 16'(HALT_MS);
    end
  end

endmodule

`default_nettype wire

// *** hw/cpd_detect.sv ***
/*
 * Decision and configuration logic of a single-channel capacitive
 * proximity and touch detector: option banks, thresholds, long-term
 * average with dynamic recalibration, detect and control pins, interrupt.
 * Assumes sample counts arrive from a front end on the same clock, and
 * that the host drives the control pin from another clock domain.
 */
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module cpd_detect #(
  parameter int TICK_CYC = cpd_pkg::TICK_CYCLES,
  parameter int RECAL_MS = cpd_pkg::RECAL_DELAY_MS,
  parameter int EXT_HALT = cpd_pkg::EXT_HALT_MS
) (
  // Clock, reset, enable
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        clk_en,
  // Register port
  input  wire logic [cpd_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [cpd_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [cpd_pkg::DATA_W-1:0]  reg_rdata,
  // Front end
  input  wire logic                        sample_valid,
  input  wire logic [cpd_pkg::CNT_W-1:0]   sample_count,
  output logic                             charge_halt,
  output logic      [cpd_pkg::CNT_W-1:0]   tuning_base,
  output logic                             stream_en,
  // Detect pin, open-drain capable
  output logic                             detect_o,
  output logic                             detect_oe,
  // Control pin, two-way
  input  wire logic                        ctrl_i,
  output logic                             ctrl_o,
  output logic                             ctrl_oe,
  // Interrupt
  output logic                             irq
);
  import cpd_pkg::*;

  initial begin
    if (TICK_CYC < 2 || TICK_CYC > 65536 || RECAL_MS < 1 || RECAL_MS > 65535) begin
      $error("cpd_detect: bad timing parameter");
    end
  end

  function automatic logic [CNT_W-1:0] touch_thr(input logic [2:0] code);
    case (code)
      3'h0: touch_thr = 16'd16;
      3'h1: touch_thr = 16'd40;
      3'h2: touch_thr = 16'd60;
      3'h3: touch_thr = 16'd90;
      3'h4: touch_thr = 16'd130;
      3'h5: touch_thr = 16'd200;
      3'h6: touch_thr = 16'd340;
      default: touch_thr = 16'd500;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] prox_thr(input logic [1:0] code);
    prox_thr = {12'h000, code, 2'b00} + 16'd4;
  endfunction

  function automatic logic [CNT_W-1:0] base_cnt(input logic [1:0] code);
    case (code)
      2'h0: base_cnt = 16'd200;
      2'h1: base_cnt = 16'd100;
      2'h2: base_cnt = 16'd150;
      default: base_cnt = 16'd250;
    endcase
  endfunction

  // Halt time in ms; zero stands for "halt for ever"
  function automatic logic [16:0] halt_ms(input logic [1:0] code);
    case (code)
      2'h1: halt_ms = 17'(HALT_18_S * MS_PER_S);
      2'h2: halt_ms = 17'(HALT_60_S * MS_PER_S);
      2'h3: halt_ms = 17'(HALT_3_S * MS_PER_S);
      default: halt_ms = 17'h00000;
    endcase
  endfunction

  // Step the average one count toward the sample
  function automatic logic [CNT_W-1:0] track(input logic [CNT_W-1:0] avg,
                                             input logic [CNT_W-1:0] cnt);
    if (cnt > avg) begin
      track = avg + 16'h0001;
    end else if (cnt < avg) begin
      track = avg - 16'h0001;
    end else begin
      track = avg;
    end
  endfunction

  logic [7:0]       bank0_q;
  logic [7:0]       bank1_q;
  logic [7:0]       bank2_q;
  logic [EV_N-1:0]  int_stat_q;
  logic [EV_N-1:0]  int_en_q;
  logic [EV_N-1:0]  ev;
  logic [CNT_W-1:0] lta_q;
  logic             seeded_q;
  logic [16:0]      halt_cnt_q;
  logic [15:0]      recal_cnt_q;
  logic [15:0]      tick_q;
  logic             ms_tick;
  logic             ctrl_level;
  logic             ext_hold;
  logic             ext_reseed;
  logic             ext_release;
  logic             reseed_req_q;
  cpd_state_t       state_q;
  cpd_state_t       state_d;

  // Option fields; masked banks keep unimplemented bits at zero
  logic [CNT_W-1:0] touch_threshold_sel;
  logic [CNT_W-1:0] pthr;
  logic             pol_high;
  logic             mode_filter;
  logic             dir_out;
  logic [16:0]      halt_lim;

  assign touch_threshold_sel = touch_thr(bank0_q[TOUCH_THRESHOLD_SEL_LSB+:3]);
  assign pthr = prox_thr(bank0_q[PTHR_LSB+:2]);
  assign pol_high = bank0_q[POL_BIT] && !bank1_q[STREAM_BIT];
  assign mode_filter = bank0_q[EXTMODE_BIT];
  assign dir_out = bank1_q[DIR_BIT];
  assign halt_lim = halt_ms(bank1_q[HALT_LSB+:2]);

  // Count drop below the average is the signal
  logic [CNT_W-1:0] drop;
  logic [CNT_W-1:0] rise;
  logic             is_prox;
  logic             is_touch;
  logic             is_release;
  logic             take;
  logic             filt_halt;
  logic             halt_expired;
  logic             recal_due;

  assign drop = (lta_q > sample_count) ? lta_q - sample_count : 16'h0000;
  assign rise = (sample_count > lta_q) ? sample_count - lta_q : 16'h0000;
  assign is_prox = drop > pthr;
  assign is_touch = drop > touch_threshold_sel;
  assign is_release = rise > pthr;
  assign take = sample_valid && !charge_halt && seeded_q;
  assign filt_halt = ext_hold && mode_filter;
  assign halt_expired = halt_lim != 17'h00000 && halt_cnt_q >= halt_lim;
  assign recal_due = recal_cnt_q >= 16'(RECAL_MS);

  // Millisecond time base
  assign ms_tick = tick_q == 16'(TICK_CYC - 1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_q <= 16'h0000;
    end else if (clk_en) begin
      tick_q <= ms_tick ? 16'h0000 : tick_q + 16'h0001;
    end
  end

  cpd_pin_sync #(
    .RST_VAL (1'b0)
  ) u_ctrl_sync (
    .clk     (clk),
    .rstn    (rstn),
    .clk_en  (clk_en),
    .pin_i   (ctrl_i),
    .level_o (ctrl_level)
  );

  // Host control only counts while the pin is an input
  cpd_ctrl_timer #(
    .HALT_MS (EXT_HALT)
  ) u_ctrl_timer (
    .clk        (clk),
    .rstn       (rstn),
    .clk_en     (clk_en),
    .enable     (!dir_out),
    .ms_tick    (ms_tick),
    .ctrl_level (ctrl_level),
    .hold_o     (ext_hold),
    .reseed_o   (ext_reseed),
    .release_o  (ext_release)
  );

  // Option banks and interrupt registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bank0_q <= RST_THRESHOLD_LOGIC;
      bank1_q <= RST_HALT_STREAM;
      bank2_q <= RST_TUNING_BASE;
      int_en_q <= '0;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        OFS_THRESHOLD_LOGIC: bank0_q <= reg_wdata & MASK_BANK0;
        OFS_HALT_STREAM: bank1_q <= reg_wdata & MASK_BANK1;
        OFS_TUNING_BASE: bank2_q <= reg_wdata & MASK_BANK2;
        OFS_INT_ENABLE: int_en_q <= reg_wdata[EV_N-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_stat_q <= '0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == OFS_INT_CLEAR) begin
        int_stat_q <= (int_stat_q & ~reg_wdata[EV_N-1:0]) | ev;
      end else begin
        int_stat_q <= int_stat_q | ev;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(int_stat_q & int_en_q);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          OFS_THRESHOLD_LOGIC: reg_rdata <= bank0_q;
          OFS_HALT_STREAM: reg_rdata <= bank1_q;
          OFS_TUNING_BASE: reg_rdata <= bank2_q;
          OFS_STATE: reg_rdata <= {3'h0, filt_halt, charge_halt, seeded_q, state_q};
          OFS_INT_STATUS: reg_rdata <= {3'h0, int_stat_q};
          OFS_INT_ENABLE: reg_rdata <= {3'h0, int_en_q};
          OFS_LTA_LO: reg_rdata <= lta_q[7:0];
          OFS_LTA_HI: reg_rdata <= lta_q[15:8];
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Charge halt and the reseed request that follows it or a pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      charge_halt <= 1'b0;
      reseed_req_q <= 1'b0;
    end else if (clk_en) begin
      // Front end finishes its running cycle before honouring this
      charge_halt <= ext_hold && !mode_filter;
      if (ext_reseed || (ext_release && !mode_filter)) begin
        reseed_req_q <= 1'b1;
      end else if (sample_valid && !charge_halt) begin
        reseed_req_q <= 1'b0;
      end
    end
  end

  // Detection state machine
  always_comb begin
    state_d = state_q;
    if (take) begin
      case (state_q)
        CPD_IDLE: begin
          if (is_prox) begin
            state_d = CPD_PROX;
          end
        end
        CPD_PROX: begin
          if (is_touch) begin
            state_d = CPD_TOUCH;
          end else if (!is_prox || halt_expired) begin
            state_d = CPD_IDLE;
          end
        end
        CPD_TOUCH: begin
          if (recal_due) begin
            state_d = CPD_TRACK;
          end else if (!is_prox) begin
            state_d = CPD_IDLE;
          end
        end
        CPD_TRACK: begin
          if (is_release) begin
            state_d = CPD_IDLE;
          end
        end
        default: state_d = CPD_IDLE;
      endcase
    end
    if (reseed_req_q) begin
      state_d = CPD_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= CPD_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  always_comb begin
    ev = '0;
    ev[EV_PROX] = state_q == CPD_IDLE && state_d == CPD_PROX;
    ev[EV_TOUCH] = state_q == CPD_PROX && state_d == CPD_TOUCH;
    ev[EV_RECAL] = state_q == CPD_TOUCH && state_d == CPD_TRACK;
    ev[EV_RELEASE] = state_q == CPD_TRACK && state_d == CPD_IDLE;
    ev[EV_RESEED] = reseed_req_q && sample_valid && !charge_halt;
  end

  // Halt and recalibration timers in ms
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      halt_cnt_q <= 17'h00000;
      recal_cnt_q <= 16'h0000;
    end else if (clk_en) begin
      if (state_q == CPD_IDLE || state_q == CPD_TRACK) begin
        halt_cnt_q <= 17'h00000;
      end else if (ms_tick && halt_cnt_q != 17'h1ffff) begin
        halt_cnt_q <= halt_cnt_q + 17'h00001;
      end
      if (state_q != CPD_TOUCH) begin
        recal_cnt_q <= 16'h0000;
      end else if (ms_tick && !recal_due) begin
        recal_cnt_q <= recal_cnt_q + 16'h0001;
      end
    end
  end

  // Long-term average
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lta_q <= 16'h0000;
      seeded_q <= 1'b0;
    end else if (clk_en && sample_valid && !charge_halt) begin
      if (!seeded_q || reseed_req_q) begin
        lta_q <= sample_count;
        seeded_q <= 1'b1;
      end else if (state_q == CPD_TOUCH && recal_due) begin
        // Halted average less the touch threshold, as touch mode base
        lta_q <= (lta_q > touch_threshold_sel) ? lta_q - touch_threshold_sel : 16'h0000;
      end else if (state_q == CPD_PROX && halt_expired) begin
        lta_q <= sample_count;
      end else if (filt_halt) begin
        lta_q <= lta_q;
      end else if (state_q == CPD_IDLE || state_q == CPD_TRACK) begin
        // Slow one-count steps so a fast touch drags the average one count per sample at most
        lta_q <= track(lta_q, sample_count);
      end
    end
  end

  // Pins and front-end settings
  logic active;

  assign active = state_q != CPD_IDLE;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      detect_o <= 1'b0;
      detect_oe <= 1'b0;
      ctrl_o <= 1'b0;
      ctrl_oe <= 1'b0;
      stream_en <= 1'b0;
      tuning_base <= 16'd200;
    end else if (clk_en) begin
      if (pol_high) begin
        detect_o <= active;
        detect_oe <= 1'b1;
      end else begin
        // Open drain: pull low when active, else release the pin
        detect_o <= 1'b0;
        detect_oe <= active;
      end
      ctrl_o <= dir_out && (pol_high ? active : !active);
      ctrl_oe <= dir_out;
      stream_en <= bank1_q[STREAM_BIT];
      tuning_base <= base_cnt(bank2_q[BASE_LSB+:2]);
    end
  end

endmodule

`default_nettype wire

// *** dv/cpd_detect_asserts.sv ***
/* Port checker of the detect block, bound to every cpd_detect.
   Assumes clk_en is held high and sees only the block's ports. */
`timescale 1ns/1ps
`default_nettype none
module cpd_detect_asserts #(
  parameter int TICK_CYC = cpd_pkg::TICK_CYCLES,
  parameter int EXT_HALT = cpd_pkg::EXT_HALT_MS
) (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rstn,
  // Register port
  input wire logic [cpd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cpd_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [cpd_pkg::DATA_W-1:0] reg_rdata,
  // Outputs and control pin
  input wire logic                       charge_halt,
  input wire logic [cpd_pkg::CNT_W-1:0]  tuning_base,
  input wire logic                       stream_en,
  input wire logic                       detect_o,
  input wire logic                       detect_oe,
  input wire logic                       ctrl_i,
  input wire logic                       ctrl_oe
);
  import cpd_pkg::*;
  logic [8:0] high_q;
  // Saturates: it only has to reach the halt time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      high_q <= 9'h000;
    end else if (!ctrl_i) begin
      high_q <= 9'h000;
    end else if (high_q != 9'h1ff) begin
      high_q <= high_q + 9'h001;
    end
  end
  function automatic logic [15:0] base_of(input logic [1:0] c);
    return c == 2'h0 ? 16'h00c8 : c == 2'h1 ? 16'h0064 : c == 2'h2 ? 16'h0096 : 16'h00fa;
  endfunction
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  reset_vals_a: assert property (
    $rose(rstn) |-> tuning_base == 16'h00c8 && !detect_oe && !ctrl_oe)
    else $error("outputs off their reset values");
  polarity_low_a: assert property (
    reg_wr && reg_addr == OFS_THRESHOLD_LOGIC && !reg_wdata[POL_BIT]
    ##1 !(reg_wr && reg_addr == OFS_THRESHOLD_LOGIC) |=> !detect_o)
    else $error("open drain detect drove high");
  dir_follow_a: assert property (
    reg_wr && reg_addr == OFS_HALT_STREAM |-> ##2 ctrl_oe == $past(reg_wdata[DIR_BIT], 2))
    else $error("control pin enable off direction bit");
  stream_bit_a: assert property (
    reg_wr && reg_addr == OFS_HALT_STREAM |-> ##2 stream_en == $past(reg_wdata[STREAM_BIT], 2))
    else $error("stream enable off its bit");
  base_table_a: assert property (
    reg_wr && reg_addr == OFS_TUNING_BASE
    |-> ##2 tuning_base == base_of($past(reg_wdata[2:1], 2)))
    else $error("tuning base off table");
  mask_read_a: assert property (
    reg_wr && reg_addr == OFS_THRESHOLD_LOGIC ##1 !reg_wr
    ##1 reg_rd && !reg_wr && reg_addr == OFS_THRESHOLD_LOGIC
    |=> reg_rdata == ($past(reg_wdata, 3) & MASK_BANK0))
    else $error("option bank read back unmasked");
  unmapped_zero_a: assert property (
    reg_rd && reg_addr > OFS_LTA_HI |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  halt_hold_a: assert property (
    $rose(charge_halt) |-> int'(high_q) >= (EXT_HALT - 1) * TICK_CYC)
    else $error("charge halt before halt time");
  halt_release_a: assert property (
    $fell(ctrl_i) |-> ##[1:12] !charge_halt)
    else $error("charge halt outlived control");
endmodule
bind cpd_detect cpd_detect_asserts #(.TICK_CYC(TICK_CYC), .EXT_HALT(EXT_HALT)) u_asserts (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .charge_halt(charge_halt),
  .tuning_base(tuning_base), .stream_en(stream_en), .detect_o(detect_o),
  .detect_oe(detect_oe), .ctrl_i(ctrl_i), .ctrl_oe(ctrl_oe));
`default_nettype wire

// *** dv/cpd_host_model.sv ***
/* Host controller beside the detect block: drives the control pin
   while it is an input, sees both pins as wires. Assumes a pull-up
   on the detect pin only. */
`timescale 1ns/1ps
`default_nettype none
module cpd_host_model (
  // Clock
  input  wire logic clk,
  // Device pins
  input  wire logic detect_o,
  input  wire logic detect_oe,
  input  wire logic ctrl_o,
  input  wire logic ctrl_oe,
  output logic      ctrl_i,
  output logic      detect_pin
);
  logic drv_q = 1'b0;
  // Released open drain floats up
  assign detect_pin = detect_oe ? detect_o : 1'b1;
  assign ctrl_i = ctrl_oe ? ctrl_o : drv_q;
  // Short hold is a reseed pulse, long one a halt
  task automatic hold(input int n);
    @(posedge clk);
    drv_q <= 1'b1;
    repeat (n) @(posedge clk);
    drv_q <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** dv/test_capacitive_detect_config.sv ***
/* Self-checking bench of the detect block: options, thresholds,
   recalibration, interrupt and host control. Assumes the host model
   and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_capacitive_detect_config;
  import cpd_pkg::*;
  localparam int TK = 4;
  localparam int RC = 3;
  logic                clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, smp_v = 1'b0;
  logic [ADDR_W-1:0]   reg_addr = 4'h0;
  logic [DATA_W-1:0]   reg_wdata = 8'h00, reg_rdata, v;
  logic [CNT_W-1:0]    smp_c = 16'h0000, tuning_base;
  logic                charge_halt, stream_en, det_o, det_oe, ctrl_i, ctrl_o, ctrl_oe, irq, pin;
  logic [7:0]          msk[3] = '{MASK_BANK0, MASK_BANK1, MASK_BANK2};
  logic [31:0]         rnd = 32'h012c15b0;
  int                  mismatches = 0, comparisons = 0;
  int                  tt[8] = '{16, 40, 60, 90, 130, 200, 340, 500}, pt[4] = '{4, 8, 12, 16};
  int                  bs[4] = '{200, 100, 150, 250};
  always #25 clk = ~clk;
  cpd_detect #(.TICK_CYC(TK), .RECAL_MS(RC)) u_dut (.clk(clk), .rstn(rstn), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_valid(smp_v), .sample_count(smp_c),
    .charge_halt(charge_halt), .tuning_base(tuning_base), .stream_en(stream_en),
    .detect_o(det_o), .detect_oe(det_oe), .ctrl_i(ctrl_i), .ctrl_o(ctrl_o),
    .ctrl_oe(ctrl_oe), .irq(irq));
  cpd_host_model u_host (.clk(clk), .detect_o(det_o), .detect_oe(det_oe), .ctrl_o(ctrl_o),
    .ctrl_oe(ctrl_oe), .ctrl_i(ctrl_i), .detect_pin(pin));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_cnt(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // Pins packed; control level counts only while driven
  task automatic chk_pins(input logic [7:0] e);
    chk_reg("pins", e, {irq, charge_halt, stream_en, pin, det_o, det_oe, ctrl_oe,
      ctrl_oe & ctrl_o});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic smp(input int c);
    smp_c <= 16'(c);
    smp_v <= 1'b1;
    @(posedge clk);
    smp_v <= 1'b0;
    #1;
  endtask
  task automatic cst(input logic [7:0] e);
    rd(OFS_STATE);
    chk_reg("state", e, v & 8'h03);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      rd(4'(i));
      chk_reg("bank", 8'h00, v);
    end
    rd(4'hf);
    chk_reg("unmapped", 8'h00, v);
    chk_cnt("base", 16'h00c8, tuning_base);
    chk_pins(8'h10);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      wr(4'(i % 3), rnd[7:0]);
      rd(4'(i % 3));
      chk_reg("bank", rnd[7:0] & msk[i % 3], v);
    end
    for (int c = 0; c < 4; c++) begin
      wr(OFS_TUNING_BASE, 8'(c << 1));
      chk_cnt("base", 16'(bs[c]), tuning_base);
    end
    wr(OFS_HALT_STREAM, 8'h80);
    chk_pins(8'h30);
    wr(OFS_HALT_STREAM, 8'h00);
    $display("option test done");
    smp(1000);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_THRESHOLD_LOGIC, 8'(8'he0 | (p << 3)));
      smp(999 - pt[p]);
      cst(8'h01);
      chk_pins(8'h04);
      smp(1000);
      // Idle tracking has pulled the average one count down
      smp(999 - pt[p]);
      cst(8'h00);
      repeat (2) smp(1000);
    end
    for (int t = 0; t < 8; t++) begin
      wr(OFS_THRESHOLD_LOGIC, 8'(t << 5));
      smp(1000 - tt[t]);
      cst(8'h01);
      smp(998 - tt[t]);
      cst(8'h03);
      repeat (2) smp(1000);
      cst(8'h00);
    end
    $display("threshold test done");
    wr(OFS_INT_ENABLE, 8'h1f);
    wr(OFS_HALT_STREAM, 8'h01);
    wr(OFS_THRESHOLD_LOGIC, 8'h02);
    smp(995);
    cst(8'h01);
    chk_pins(8'h9f);
    smp(982);
    repeat ((RC + 2) * TK) @(posedge clk);
    // Recalibration is only applied on a taken sample
    smp(982);
    cst(8'h02);
    rd(OFS_INT_STATUS);
    chk_reg("status", 8'h07, v);
    wr(OFS_INT_CLEAR, 8'h1f);
    chk_reg("irq", 8'h00, {7'h00, irq});
    smp(1000);
    cst(8'h00);
    chk_pins(8'h86);
    wr(OFS_INT_ENABLE, 8'h00);
    rd(OFS_INT_STATUS);
    chk_reg("status", 8'h08, v);
    chk_pins(8'h06);
    wr(OFS_HALT_STREAM, 8'h00);
    wr(OFS_THRESHOLD_LOGIC, 8'h00);
    $display("recalibration test done");
    smp(970);
    cst(8'h01);
    chk_pins(8'h04);
    u_host.hold(30 * TK);
    repeat (8) @(posedge clk);
    smp(990);
    cst(8'h00);
    chk_pins(8'h10);
    rd(OFS_LTA_LO);
    chk_reg("avg_lo", 8'hde, v);
    rd(OFS_LTA_HI);
    chk_reg("avg_hi", 8'h03, v);
    for (int m = 0; m < 2; m++) begin
      wr(OFS_THRESHOLD_LOGIC, 8'(m));
      fork
        u_host.hold(45 * TK);
        begin
          repeat (44 * TK) @(posedge clk);
          if (m == 0) smp(900);
          #1;
          chk_pins(8'(m == 0 ? 8'h50 : 8'h10));
        end
      join
      repeat (12) @(posedge clk);
      #1;
      chk_pins(8'h10);
      cst(8'h00);
    end
    $display("control test done");
    summarize();
  end
endmodule
`default_nettype wire
